// File: rtl/altmode_consts.svh
`ifndef ALTMODE_CONSTS_SVH
`define ALTMODE_CONSTS_SVH

// Clock rate
`define CLK_MHZ 40

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DP_GAIN 8'h04
`define OFS_USB_GAIN 8'h08
`define OFS_STATUS 8'h0C

// Control register fields
`define CTRL_USB_SEL 0
`define CTRL_DP_SEL 1
`define CTRL_ORIENT 2
`define CTRL_SB_FORCE 3

// Gain register fields, four bits each
`define GAIN_W 4
`define USB_GAIN_DS1 0
`define USB_GAIN_DS2 4
`define USB_GAIN_UP 8

// Status register fields
`define STAT_REG_MODE 0
`define STAT_PWR_GOOD 1
`define STAT_LINK 2
`define STAT_USB_EN 4
`define STAT_DP_LANES 5
`define STAT_FLIP 8
`define STAT_PULL_EN 9

// Reset values
`define CTRL_RST 4'h0
`define DP_GAIN_RST 16'h0000
`define USB_GAIN_RST 12'h000

// Four-level strap code for level 0
`define LVL_ZERO 2'h0

// Times in their own units
`define PG_DELAY_US 500
`define STRAP_HOLD_US 10
`define DEBOUNCE_MS 16
`define U1_IDLE_US 100
`define RXDET_PERIOD_US 100

// Cycle counts; least times round up, longest round down
`define PG_DELAY_CYC (`PG_DELAY_US * `CLK_MHZ)
`define STRAP_HOLD_CYC (`STRAP_HOLD_US * `CLK_MHZ)
`define DEBOUNCE_CYC (`DEBOUNCE_MS * 1000 * `CLK_MHZ)
`define U1_IDLE_CYC (`U1_IDLE_US * `CLK_MHZ)
`define RXDET_PERIOD_CYC (`RXDET_PERIOD_US * `CLK_MHZ)

`endif

// File: rtl/altmode_pkg.sv
package altmode_pkg;

   // Four-level pin: 0 = level 0, 1 = R, 2 = F, 3 = level 1
   typedef logic [1:0] lvl4_t;

   typedef enum logic [1:0] {
      LS_DISCONNECT,
      LS_U0,
      LS_U1,
      LS_U23
   } link_state_t;

   typedef struct packed {
      logic pwr_down;
      logic usb_en;
      logic [2:0] dp_lanes;
      logic flip;
   } lane_cfg_t;

   typedef struct packed {
      logic auxp_sbu1;
      logic auxp_sbu2;
      logic auxn_sbu1;
      logic auxn_sbu2;
   } sbu_map_t;

   typedef struct packed {
      logic ufp_term;
      logic dfp_term;
      logic ufp_eidle;
      logic dfp_eidle;
      logic lfps_valid;
      logic ss_active;
      logic rxdet_done;
   } phy_obs_t;

   typedef struct packed {
      logic redrive_en;
      logic rx_term_en;
      logic tx_cm_hold;
      logic rxdet_req;
   } phy_ctl_t;

   typedef struct packed {
      logic [3:0] lane0_gain_setting;
      logic [3:0] lane1_gain_setting;
      logic [3:0] lane2_gain_setting;
      logic [3:0] lane3_gain_setting;
      logic [3:0] downstream1_gain_setting;
      logic [3:0] downstream2_gain_setting;
      logic [3:0] upstream_gain_setting;
   } gain_set_t;

endpackage

// File: rtl/altmode_switch_mode_ctrl.sv
// Overview of operation
// (RULE1) Mode strap not at level 0 selects register configuration, same choices as pins.
// (RULE2) Both selects low powers down; USB select alone runs one USB port, flip applied.
// (RULE3) Display select alone routes four display lanes, flip applied.
// (RULE4) Both selects high run one USB port plus two display lanes, flip applied.
// (RULE5) No override: display on maps sideband by orientation; display off leaves it open.
// (RULE6) Override set: AUXp to SBU2, AUXn to SBU1, whatever else holds; the code applies the override only in register mode.
// (RULE7) In register mode display enable comes only from the register, pins ignored.
// (RULE8) Separate gain per display lane, downstream receiver and upstream receiver.
// (RULE9) Pin mode gain of each group comes from its two four-level straps.
// (RULE10) Link tracker runs only while USB is enabled.
// (RULE11) Link state follows termination, idle, low-frequency signalling and rate; the code has no rate input and ignores rate.
// (RULE12) Disconnect waits for termination on both ports, then goes to U0.
// (RULE13) U0 redrives both ports; idle on both ports moves to U1.
// (RULE14) U1 keeps receiver termination and transmitter common mode.
// (RULE15) U1 goes to U2/U3 after long idle, back to U0 on activity.
// (RULE16) U2/U3 repeats receiver detection; missing termination goes to Disconnect.
// (RULE17) U2/U3 enters U0 on valid low-frequency signalling.
// (RULE18) U2/U3 keeps termination but drops transmitter common mode.
// (RULE19) Internal power good rises within 500 us of reset release.
// (RULE20) Straps are held stable 50 us before to 10 us after power good.
// (RULE21) Straps latch at power good rise; pulls disconnect after the hold time.
// (RULE22) Select and orientation pins debounced, applied within 16 ms.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "altmode_consts.svh"

module altmode_switch_mode_ctrl
   import altmode_pkg::*;
#(
   parameter int unsigned PG_DELAY_CYC = `PG_DELAY_CYC,
   parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Strap pins
   input wire lvl4_t mode_strap,
   input wire lvl4_t [1:0] downstream_gain_straps,
   input wire lvl4_t [1:0] display_gain_straps,
   input wire lvl4_t [1:0] upstream_gain_straps,
   output logic strap_pull_en,
   output logic power_good,
   // Control pins
   input wire logic usb_select_pin,
   input wire logic display_select_pin,
   input wire logic orientation_pin,
   // Switch control
   output lane_cfg_t lane_cfg,
   output sbu_map_t sbu_map,
   output gain_set_t gains,
   // USB link
   input wire phy_obs_t phy_obs,
   output phy_ctl_t phy_ctl,
   output link_state_t link_state
);

   localparam logic [19:0] DB_LAST = 20'(DEBOUNCE_CYC - 1);
   localparam logic [15:0] PG_LAST = 16'(PG_DELAY_CYC - 1);
   localparam logic [15:0] HOLD_LAST = 16'(`STRAP_HOLD_CYC - 1);
   localparam logic [15:0] U1_LAST = 16'(`U1_IDLE_CYC - 1);
   localparam logic [15:0] RXDET_LAST = 16'(`RXDET_PERIOD_CYC - 1);

   logic [15:0] pg_cnt_r;
   logic pwr_good_r;
   logic [15:0] hold_cnt_r;
   logic pull_en_r;
   logic reg_mode_r;
   lvl4_t [5:0] strap_r;
   logic [3:0] ctrl_r;
   logic [15:0] dp_gain_r;
   logic [11:0] usb_gain_r;
   logic [2:0] pin_raw;
   logic [2:0] pin_db_r;
   logic usb_sel;
   logic dp_sel;
   logic flip_sel;
   logic usb_on;
   link_state_t state_r;
   link_state_t state_nxt;
   logic [15:0] idle_cnt_r;
   logic [15:0] rxdet_cnt_r;
   logic rxdet_req_r;
   logic both_term;
   logic both_idle;
   logic [31:0] rd_nxt;
   logic hit;
   logic wr_en;

   // Power good, then strap hold window
   // (RULE19) Power good delay
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pg_cnt_r <= 16'h0000;
         pwr_good_r <= 1'b0;
      end
      else if (!pwr_good_r)
      begin
         if (pg_cnt_r == PG_LAST)
            pwr_good_r <= 1'b1;
         else
            pg_cnt_r <= pg_cnt_r + 16'h0001;
      end
   end

   // (RULE21) Pull disconnect after hold
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_cnt_r <= 16'h0000;
         pull_en_r <= 1'b1;
      end
      else if (pwr_good_r && pull_en_r)
      begin
         if (hold_cnt_r == HOLD_LAST)
            pull_en_r <= 1'b0;
         else
            hold_cnt_r <= hold_cnt_r + 16'h0001;
      end
   end

   // Straps are sampled by a clocked process at the power good rise,
   // which keeps the asynchronous reset free of port values.
   // (RULE21) Latch straps at rise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg_mode_r <= 1'b0;
         strap_r <= '0;
      end
      else if (!pwr_good_r && pg_cnt_r == PG_LAST)
      begin
         // (RULE1) Mode strap decode
         reg_mode_r <= (mode_strap != `LVL_ZERO);
         strap_r <= {upstream_gain_straps, display_gain_straps, downstream_gain_straps};
      end
   end

   // Select pins debounced: a new level must stay put for the whole
   // window, so short glitches from the port controller never reach the mux.
   assign pin_raw = {orientation_pin, display_select_pin, usb_select_pin};

   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_db
         logic [19:0] cnt_r;
         // (RULE22) Debounce window
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cnt_r <= 20'h00000;
               pin_db_r[i] <= 1'b0;
            end
            else if (pin_raw[i] == pin_db_r[i])
               cnt_r <= 20'h00000;
            else if (cnt_r == DB_LAST)
            begin
               cnt_r <= 20'h00000;
               pin_db_r[i] <= pin_raw[i];
            end
            else
               cnt_r <= cnt_r + 20'h00001;
         end
      end
   endgenerate

   // Source of the selects
   // (RULE7) Register mode ignores pins
   always_comb
   begin
      if (reg_mode_r)
      begin
         usb_sel = ctrl_r[`CTRL_USB_SEL];
         dp_sel = ctrl_r[`CTRL_DP_SEL];
         flip_sel = ctrl_r[`CTRL_ORIENT];
      end
      else
      begin
         usb_sel = pin_db_r[0];
         dp_sel = pin_db_r[1];
         flip_sel = pin_db_r[2];
      end
   end

   // Lane configuration; nothing runs before power good
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lane_cfg <= '{pwr_down: 1'b1, usb_en: 1'b0, dp_lanes: 3'h0, flip: 1'b0};
      else
      begin
         // (RULE2) Power down or USB only
         lane_cfg.pwr_down <= !pwr_good_r || (!usb_sel && !dp_sel);
         lane_cfg.usb_en <= pwr_good_r && usb_sel;
         lane_cfg.flip <= flip_sel;
         // (RULE3) Four display lanes
         // (RULE4) USB plus two display lanes
         if (!pwr_good_r || !dp_sel)
            lane_cfg.dp_lanes <= 3'h0;
         else if (usb_sel)
            lane_cfg.dp_lanes <= 3'h2;
         else
            lane_cfg.dp_lanes <= 3'h4;
      end
   end

   // Sideband routing; the override only exists as a register bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sbu_map <= '0;
      else if (reg_mode_r && ctrl_r[`CTRL_SB_FORCE])
         // (RULE6) Forced swap
         sbu_map <= '{auxp_sbu1: 1'b0, auxp_sbu2: 1'b1, auxn_sbu1: 1'b1, auxn_sbu2: 1'b0};
      else if (!pwr_good_r || !dp_sel)
         // (RULE5) Open when deselected
         sbu_map <= '0;
      else
         // (RULE5) Orientation mapping
         sbu_map <= '{auxp_sbu1: !flip_sel, auxp_sbu2: flip_sel, auxn_sbu1: flip_sel, auxn_sbu2: !flip_sel};
   end

   // Gains; each group of straps pairs into one of sixteen settings
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gains <= '0;
      else if (reg_mode_r)
      begin
         // (RULE8) Per receiver register gain
         gains.lane0_gain_setting <= dp_gain_r[3:0];
         gains.lane1_gain_setting <= dp_gain_r[7:4];
         gains.lane2_gain_setting <= dp_gain_r[11:8];
         gains.lane3_gain_setting <= dp_gain_r[15:12];
         gains.downstream1_gain_setting <= usb_gain_r[`USB_GAIN_DS1 +: `GAIN_W];
         gains.downstream2_gain_setting <= usb_gain_r[`USB_GAIN_DS2 +: `GAIN_W];
         gains.upstream_gain_setting <= usb_gain_r[`USB_GAIN_UP +: `GAIN_W];
      end
      else
      begin
         // (RULE9) Strap pair gain
         gains.lane0_gain_setting <= {strap_r[3], strap_r[2]};
         gains.lane1_gain_setting <= {strap_r[3], strap_r[2]};
         gains.lane2_gain_setting <= {strap_r[3], strap_r[2]};
         gains.lane3_gain_setting <= {strap_r[3], strap_r[2]};
         gains.downstream1_gain_setting <= {strap_r[1], strap_r[0]};
         gains.downstream2_gain_setting <= {strap_r[1], strap_r[0]};
         gains.upstream_gain_setting <= {strap_r[5], strap_r[4]};
      end
   end

   // USB link state tracker
   // (RULE10) Runs only with USB enabled
   assign usb_on = pwr_good_r && usb_sel;
   // (RULE11) Observed conditions
   assign both_term = phy_obs.ufp_term && phy_obs.dfp_term;
   assign both_idle = phy_obs.ufp_eidle && phy_obs.dfp_eidle && !phy_obs.ss_active;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         LS_DISCONNECT:
            // (RULE12) Termination on both ports
            if (both_term)
               state_nxt = LS_U0;
         LS_U0:
            // (RULE13) Idle on both ports
            if (both_idle)
               state_nxt = LS_U1;
         LS_U1:
            // (RULE15) Idle timeout or resume
            if (!both_idle)
               state_nxt = LS_U0;
            else if (idle_cnt_r == U1_LAST)
               state_nxt = LS_U23;
         LS_U23:
            // (RULE16) Lost termination wins
            if (phy_obs.rxdet_done && !both_term)
               state_nxt = LS_DISCONNECT;
            // (RULE17) Wake on valid signalling
            else if (phy_obs.lfps_valid)
               state_nxt = LS_U0;
      endcase
      if (!usb_on)
         state_nxt = LS_DISCONNECT;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= LS_DISCONNECT;
      else
         state_r <= state_nxt;
   end

   // U1 idle timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         idle_cnt_r <= 16'h0000;
      else if (state_r != LS_U1 || !both_idle)
         idle_cnt_r <= 16'h0000;
      else if (idle_cnt_r != U1_LAST)
         idle_cnt_r <= idle_cnt_r + 16'h0001;
   end

   // Periodic detection request in Disconnect and U2/U3
   // (RULE16) Periodic receiver detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rxdet_cnt_r <= 16'h0000;
         rxdet_req_r <= 1'b0;
      end
      else if (!usb_on || state_r == LS_U0 || state_r == LS_U1)
      begin
         rxdet_cnt_r <= 16'h0000;
         rxdet_req_r <= 1'b0;
      end
      else if (rxdet_cnt_r == RXDET_LAST)
      begin
         rxdet_cnt_r <= 16'h0000;
         rxdet_req_r <= 1'b1;
      end
      else
      begin
         rxdet_cnt_r <= rxdet_cnt_r + 16'h0001;
         rxdet_req_r <= 1'b0;
      end
   end

   // Physical layer controls follow the state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phy_ctl <= '0;
      else
      begin
         // (RULE13) Redrive in U0
         phy_ctl.redrive_en <= (state_nxt == LS_U0);
         // (RULE14) Termination kept in U1
         // (RULE18) Termination kept in U2/U3
         phy_ctl.rx_term_en <= (state_nxt != LS_DISCONNECT);
         // (RULE18) Common mode dropped in U2/U3
         phy_ctl.tx_cm_hold <= (state_nxt == LS_U0 || state_nxt == LS_U1);
         phy_ctl.rxdet_req <= rxdet_req_r;
      end
   end

   assign link_state = state_r;
   assign power_good = pwr_good_r;
   assign strap_pull_en = pull_en_r;

   // APB slave with one wait state so read data comes from a flop
   assign wr_en = psel && penable && pready && pwrite && hit;

   always_comb
   begin
      hit = 1'b1;
      rd_nxt = 32'h00000000;
      unique case (paddr)
         `OFS_CTRL:
            rd_nxt[3:0] = ctrl_r;
         `OFS_DP_GAIN:
            rd_nxt[15:0] = dp_gain_r;
         `OFS_USB_GAIN:
            rd_nxt[11:0] = usb_gain_r;
         `OFS_STATUS:
         begin
            rd_nxt[`STAT_REG_MODE] = reg_mode_r;
            rd_nxt[`STAT_PWR_GOOD] = pwr_good_r;
            rd_nxt[`STAT_LINK +: 2] = state_r;
            rd_nxt[`STAT_USB_EN] = lane_cfg.usb_en;
            rd_nxt[`STAT_DP_LANES +: 3] = lane_cfg.dp_lanes;
            rd_nxt[`STAT_FLIP] = lane_cfg.flip;
            rd_nxt[`STAT_PULL_EN] = pull_en_r;
         end
         default:
            hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         prdata <= (psel && penable && !pready && !pwrite) ? rd_nxt : 32'h00000000;
         pslverr <= psel && penable && !pready && !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `CTRL_RST;
         dp_gain_r <= `DP_GAIN_RST;
         usb_gain_r <= `USB_GAIN_RST;
      end
      else if (wr_en)
      begin
         if (paddr == `OFS_CTRL)
            ctrl_r <= pwdata[3:0];
         if (paddr == `OFS_DP_GAIN)
            dp_gain_r <= pwdata[15:0];
         if (paddr == `OFS_USB_GAIN)
            usb_gain_r <= pwdata[11:0];
      end
   end

endmodule

// File: tb/altmode_switch_mode_ctrl_assertions.sv
`timescale 1ns/100ps
module altmode_switch_mode_ctrl_chk
   import altmode_pkg::*;
(
   // Clock and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Straps and switch
   input wire logic power_good,
   input wire logic strap_pull_en,
   input wire lane_cfg_t lane_cfg,
   input wire sbu_map_t sbu_map,
   // Link
   input wire phy_obs_t phy_obs,
   input wire phy_ctl_t phy_ctl,
   input wire link_state_t link_state
);
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_one_wait: assert property (psel && penable && !pready && !$past(penable) |=> pready)
      else $error("pready not in second access cycle");
   a_unmapped_error: assert property (psel && penable && pready && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})
      |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   a_dp_four_alone: assert property (lane_cfg.dp_lanes == 3'h4 |-> !lane_cfg.usb_en && !lane_cfg.pwr_down)
      else $error("four display lanes with usb or power down");
   a_usb_two_lanes: assert property (lane_cfg.usb_en && lane_cfg.dp_lanes != 3'h0
      |-> lane_cfg.dp_lanes == 3'h2) else $error("usb shares more than two lanes");
   a_sbu_pairing: assert property (sbu_map.auxp_sbu1
      |-> sbu_map.auxn_sbu2 && !sbu_map.auxp_sbu2 && !sbu_map.auxn_sbu1)
      else $error("sideband pair mapped inconsistently");
   a_disc_to_u0: assert property (link_state == LS_DISCONNECT && phy_obs.ufp_term && phy_obs.dfp_term
      && power_good && lane_cfg.usb_en ##1 lane_cfg.usb_en |-> link_state == LS_U0)
      else $error("no U0 after termination");
   a_u0_to_u1: assert property (link_state == LS_U0 && phy_obs.ufp_eidle && phy_obs.dfp_eidle
      && !phy_obs.ss_active && lane_cfg.usb_en ##1 lane_cfg.usb_en |-> link_state == LS_U1)
      else $error("no U1 after idle");
   a_u0_redrive: assert property (link_state == LS_U0 |-> phy_ctl.redrive_en && phy_ctl.tx_cm_hold)
      else $error("U0 without redrive");
   a_u1_hold: assert property (link_state == LS_U1 |-> phy_ctl.rx_term_en && phy_ctl.tx_cm_hold)
      else $error("U1 lost termination or common mode");
   a_u23_cm_drop: assert property (link_state == LS_U23 |-> phy_ctl.rx_term_en && !phy_ctl.tx_cm_hold)
      else $error("U2U3 outputs wrong");
   a_u23_term_lost: assert property (link_state == LS_U23 && phy_obs.rxdet_done
      && !(phy_obs.ufp_term && phy_obs.dfp_term) |=> link_state == LS_DISCONNECT) else $error("term loss ignored");
   a_u23_lfps_wake: assert property (link_state == LS_U23 && phy_obs.lfps_valid && !phy_obs.rxdet_done
      && lane_cfg.usb_en ##1 lane_cfg.usb_en |-> link_state == LS_U0) else $error("no wake on lfps");
   a_usb_off_disc: assert property (!lane_cfg.usb_en |-> link_state == LS_DISCONNECT)
      else $error("tracker runs without usb");
   a_pull_release: assert property ($fell(strap_pull_en) |-> power_good)
      else $error("pulls dropped before power good");
   a_pg_pulls_on: assert property ($rose(power_good) |-> strap_pull_en)
      else $error("pulls gone at strap latch");

   c_u23_seen: cover property (link_state == LS_U23);
   c_sbu_swap: cover property (sbu_map.auxp_sbu2 && sbu_map.auxn_sbu1);
   c_refused: cover property (pready && pslverr);
endmodule

bind altmode_switch_mode_ctrl altmode_switch_mode_ctrl_chk u_chk
(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .power_good(power_good),
   .strap_pull_en(strap_pull_en),
   .lane_cfg(lane_cfg),
   .sbu_map(sbu_map),
   .phy_obs(phy_obs),
   .phy_ctl(phy_ctl),
   .link_state(link_state)
);

// File: tb/apb_host_model.sv
`timescale 1ns/100ps
module apb_host_model
(
   // Clock
   input wire logic pclk,
   // Request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // Answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic hung
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hung = 1'b0;
   end

   // Request held until pready seen at an edge; gives up and flags hung after 50 more edges
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      hung = (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// File: tb/altmode_switch_mode_ctrl_tb.sv
`timescale 1ns/100ps
module altmode_switch_mode_ctrl_tb;
   import altmode_pkg::*;
   localparam int unsigned PG = 20;
   localparam int unsigned DB = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, strap_pull_en, power_good;
   logic usb_select_pin, display_select_pin, orientation_pin, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] m;
   lvl4_t mode_strap;
   lvl4_t [1:0] downstream_gain_straps, display_gain_straps, upstream_gain_straps;
   lane_cfg_t lane_cfg;
   sbu_map_t sbu_map;
   gain_set_t gains;
   phy_obs_t phy_obs;
   phy_ctl_t phy_ctl;
   link_state_t link_state;
   int fails = 0;
   int n_compared = 0;
   // Row: control value, expected lane config, expected sideband map
   logic [15:0] rows [11] = '{16'h0200, 16'h4200, 16'h1100, 16'h5110, 16'h2089, 16'h6096, 16'h3149, 16'h7156,
                              16'h8206, 16'h9106, 16'hF156};

   altmode_switch_mode_ctrl #(.PG_DELAY_CYC(PG), .DEBOUNCE_CYC(DB)) u_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_strap(mode_strap),
      .downstream_gain_straps(downstream_gain_straps), .display_gain_straps(display_gain_straps),
      .upstream_gain_straps(upstream_gain_straps), .strap_pull_en(strap_pull_en), .power_good(power_good),
      .usb_select_pin(usb_select_pin), .display_select_pin(display_select_pin),
      .orientation_pin(orientation_pin), .lane_cfg(lane_cfg), .sbu_map(sbu_map), .gains(gains),
      .phy_obs(phy_obs), .phy_ctl(phy_ctl), .link_state(link_state)
   );

   apb_host_model u_host
   (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung)
   );

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(w, a, d, rd, err);
      if (hung !== 1'b0)
      begin
         fails++;
         tally_and_finish();
      end
   endtask

   // Bounded wait; running out is a mismatch and ends the run
   task automatic wait_ls(input link_state_t s, input int lim);
      int n;
      n = 0;
      while (link_state !== s && n < lim)
      begin
         tick(1);
         n++;
      end
      chk(32'(link_state), 32'(s));
      if (link_state !== s)
         tally_and_finish();
   endtask

   task automatic do_reset(input lvl4_t mode);
      int n;
      n = 0;
      @(posedge pclk);
      presetn <= 1'b0;
      mode_strap <= mode;
      tick(1);
      chk(32'({lane_cfg.pwr_down, strap_pull_en, power_good}), 32'h6);
      tick(1);
      @(posedge pclk);
      presetn <= 1'b1;
      while (power_good !== 1'b1 && n < 1000)
      begin
         tick(1);
         n++;
      end
      chk(n, PG);
      if (power_good !== 1'b1)
         tally_and_finish();
      n = 0;
      while (strap_pull_en !== 1'b0 && n < 1000)
      begin
         tick(1);
         n++;
      end
      chk(n, 400);
      if (strap_pull_en !== 1'b0)
         tally_and_finish();
   endtask

   initial
   begin
      int n;
      presetn = 1'b0;
      mode_strap = 2'h1;
      downstream_gain_straps = 4'hC;
      display_gain_straps = 4'h9;
      upstream_gain_straps = 4'h6;
      {usb_select_pin, display_select_pin, orientation_pin} = 3'h0;
      phy_obs = 7'h00;
      do_reset(2'h1);
      for (int i = 0; i < 11; i++)
      begin
         bus(1'b1, 8'h00, {28'h0, rows[i][15:12]});
         tick(2);
         m = rows[i][9] ? 6'h3E : 6'h3F;
         chk(32'(6'(lane_cfg) & m), 32'(rows[i][9:4] & m));
         chk(32'(sbu_map), 32'(rows[i][3:0]));
         bus(1'b0, 8'h00, 32'h0);
         chk(rd, {28'h0, rows[i][15:12]});
      end
      bus(1'b1, 8'h04, 32'h0000FA50);
      bus(1'b1, 8'h08, 32'h000009C3);
      tick(2);
      chk(32'(gains), 32'h005AF3C9);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0000FA50);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF);
      bus(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h00000153);
      bus(1'b0, 8'h10, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      bus(1'b1, 8'h00, 32'h0);
      @(posedge pclk);
      {usb_select_pin, display_select_pin} <= 2'h3;
      tick(DB + 4);
      chk(32'(lane_cfg.pwr_down), 32'h1);
      @(posedge pclk);
      {usb_select_pin, display_select_pin} <= 2'h0;
      bus(1'b1, 8'h00, 32'h1);
      @(posedge pclk);
      phy_obs <= 7'h60;
      wait_ls(LS_U0, 5);
      chk(32'(phy_ctl[3:1]), 32'h7);
      phy_obs <= 7'h78;
      wait_ls(LS_U1, 5);
      chk(32'(phy_ctl[3:1]), 32'h3);
      phy_obs <= 7'h60;
      wait_ls(LS_U0, 5);
      phy_obs <= 7'h78;
      tick(3000);
      chk(32'(link_state), 32'(LS_U1));
      wait_ls(LS_U23, 1100);
      chk(32'(phy_ctl[3:1]), 32'h2);
      n = 0;
      repeat (4010)
      begin
         tick(1);
         n += phy_ctl.rxdet_req;
      end
      chk(32'(n > 0), 32'h1);
      phy_obs <= 7'h7C;
      wait_ls(LS_U0, 5);
      phy_obs <= 7'h78;
      wait_ls(LS_U23, 4100);
      phy_obs <= 7'h39;
      @(posedge pclk);
      phy_obs <= 7'h38;
      wait_ls(LS_DISCONNECT, 5);
      phy_obs <= 7'h60;
      wait_ls(LS_U0, 5);
      bus(1'b1, 8'h00, 32'h0);
      wait_ls(LS_DISCONNECT, 5);
      do_reset(2'h0);
      chk(32'(gains), 32'h09999CC6);
      @(posedge pclk);
      display_gain_straps <= 4'h0;
      tick(3);
      chk(32'(gains), 32'h09999CC6);
      @(posedge pclk);
      display_select_pin <= 1'b1;
      tick(3);
      display_select_pin <= 1'b0;
      tick(DB + 4);
      chk(32'(lane_cfg.pwr_down), 32'h1);
      @(posedge pclk);
      {display_select_pin, orientation_pin} <= 2'h3;
      tick(DB - 2);
      chk(32'(lane_cfg.pwr_down), 32'h1);
      tick(6);
      chk(32'(lane_cfg), 32'h09);
      chk(32'(sbu_map), 32'h6);
      do_reset(2'h3);
      bus(1'b0, 8'h0C, 32'h0);
      chk(32'(rd[0]), 32'h1);
      tally_and_finish();
   end
endmodule
